// [src/vofch_pkg.sv]
// package of constants for the video output image overlay fetch block
// Operation
// (RL1) image spans programmed lines and scaled width; the code uses the programmed width unscaled, upscale bit unused
// (RL2) threshold line interrupt, threshold latched per frame
// (RL3) image shifted by vertical and horizontal offsets
// (RL4) overlay first row counted within image
// (RL5) overlay first column within image, must be even
// (RL6) alpha bit picks one or zero weight
// (RL7) software keeps overlay even and inside image
// (RL8) first address: luma start or first buffer
// (RL9) second address: cb start or second buffer
// (RL10) third address: cr start or 24-bit length
// (RL11) overlay start reloads for next frame
// (RL12) overlay address is second length when streaming
// (RL13) each plane has its own 16-bit stride
// (RL14) line n address is start plus n strides
`default_nettype none
package vofch_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_IMAGE_SIZE = 8'h00;
	localparam logic [7:0] OFS_THR_POS    = 8'h04;
	localparam logic [7:0] OFS_OVL_START  = 8'h08;
	localparam logic [7:0] OFS_OVL_SIZE   = 8'h0c;
	localparam logic [7:0] OFS_ADDR_A     = 8'h10;
	localparam logic [7:0] OFS_ADDR_B     = 8'h14;
	localparam logic [7:0] OFS_ADDR_C     = 8'h18;
	localparam logic [7:0] OFS_ADDR_D     = 8'h1c;
	localparam logic [7:0] OFS_CHR_STRIDE = 8'h20;
	localparam logic [7:0] OFS_LUM_STRIDE = 8'h24;
	localparam logic [7:0] OFS_CTRL       = 8'h28;
	localparam logic [7:0] OFS_STATUS     = 8'h2c;
	localparam logic [7:0] OFS_MASK       = 8'h30;
	// field positions: 10-bit fields at 20, 10 and 0, weights at 0
	localparam int F_HI  = 20;
	localparam int F_MID = 10;
	localparam int F_LO  = 0;
	localparam int F_W   = 10;
	localparam int WGT_W = 8;
	localparam int STR_W = 16;
	localparam int LEN_W = 24;
	// control bits
	localparam int C_MODE   = 0;
	localparam int C_UPSC   = 2;
	localparam int C_AFMT   = 3;
	// status bits
	localparam int S_THR    = 0;
	localparam int S_FRAME  = 1;
	localparam int S_W      = 2;
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	// fetch modes
	typedef enum logic [1:0] {
		VOFCH_REFRESH = 2'b00,
		VOFCH_STREAM  = 2'b01,
		VOFCH_MESSAGE = 2'b10
	} vofch_mode_t;
	// plane index order
	localparam int P_LUMA = 0;
	localparam int P_CB   = 1;
	localparam int P_CR   = 2;
	localparam int P_OVL  = 3;
endpackage
`default_nettype wire

// [src/vofch_sync.sv]
// two-flip-flop synchroniser for pin inputs
`default_nettype none
module vofch_sync #(
	parameter int W = 3
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// asynchronous in, synchronous out
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_r;   // first stage, read only by second

	// two stages, nothing taps the first
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

	sync_lat_a: assert property (@(posedge mclk) disable iff (!rstn)
		$past(rstn, 2) |-> q == $past(d, 2))
		else $error("synchroniser latency wrong");
endmodule
`default_nettype wire

// [src/vofch_step.sv]
// per-plane line address stepper
`default_nettype none
module vofch_step (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// control
	input  wire logic        load,
	input  wire logic        step,
	input  wire logic [31:0] start,
	input  wire logic [15:0] stride,
	// current line address
	output var  logic [31:0] addr
);
	wire [31:0] sum = addr + {16'h0000, stride};  // no wrap inside plane

	// load at frame start, add stride per line
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			addr <= vofch_pkg::RST_ZERO;
		end else if (load) begin
			addr <= start;  // [RL14]
		end else if (step) begin
			addr <= sum;  // [RL13] [RL14]
		end
	end

	step_add_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL14]
		step && !load |=> addr == $past(addr) + {16'h0000, $past(stride)})
		else $error("line address did not advance by stride");
	step_load_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL11]
		load |=> addr == $past(start))
		else $error("start address not loaded");
endmodule
`default_nettype wire

// [src/vofch_top.sv]
// video output image placement, overlay and fetch address unit
//
// The address map and the Wishbone register port were decided locally.
`default_nettype none
module vofch_top (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	// video timing pins
	input  wire logic        frame_pin,
	input  wire logic        line_pin,
	input  wire logic        window_pin,
	// overlay pixel alpha bit from fetch
	input  wire logic        ovl_alpha_bit,
	// placement and blend outputs
	output var  logic        img_on_r,
	output var  logic        ovl_on_r,
	output var  logic [7:0]  alpha_r,
	// fetch outputs
	output var  logic        fetch_go_r,
	output var  logic [31:0] fetch_luma_r,
	output var  logic [31:0] fetch_cb_r,
	output var  logic [31:0] fetch_cr_r,
	output var  logic [31:0] fetch_ovl_r,
	output var  logic [23:0] len_one_r,
	output var  logic [23:0] len_two_r,
	// interrupt
	output var  logic        irq_r
);
	// register file
	logic [31:0] img_sz_r;    // height hi, width lo
	logic [31:0] thr_pos_r;   // threshold, voff, hoff
	logic [31:0] ovl_st_r;    // first row, first column, weight one
	logic [31:0] ovl_sz_r;    // height, width, weight zero
	logic [31:0] addr_a_r;    // luma start or first buffer
	logic [31:0] addr_b_r;    // cb start or second buffer
	logic [31:0] addr_c_r;    // cr start or first length
	logic [31:0] addr_d_r;    // overlay start or second length
	logic [31:0] chr_str_r;   // cr hi, cb lo
	logic [31:0] lum_str_r;   // overlay hi, luma lo
	logic [3:0]  ctrl_r;      // mode, upscale, alpha format
	logic [1:0]  sts_r;       // sticky events
	logic [1:0]  mask_r;      // interrupt enables

	// byte-lane merge for writes
	function automatic logic [31:0] lanes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	// 10-bit field pick
	function automatic logic [9:0] fld(input logic [31:0] v, input int p);
		return v[p +: 10];
	endfunction

	// range test: v in [lo, lo+n)
	function automatic logic inside_of(input logic [10:0] v,
		input logic [10:0] lo, input logic [10:0] n);
		logic [10:0] d;
		d = v - lo;
		return (v >= lo) && (d < n);
	endfunction

	// bus decode
	wire req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr      = req & wb_we_i;
	wire rd      = req & ~wb_we_i;
	wire wr_img  = wr & (wb_adr_i == vofch_pkg::OFS_IMAGE_SIZE);
	wire wr_thr  = wr & (wb_adr_i == vofch_pkg::OFS_THR_POS);
	wire wr_ost  = wr & (wb_adr_i == vofch_pkg::OFS_OVL_START);
	wire wr_osz  = wr & (wb_adr_i == vofch_pkg::OFS_OVL_SIZE);
	wire wr_aa   = wr & (wb_adr_i == vofch_pkg::OFS_ADDR_A);
	wire wr_ab   = wr & (wb_adr_i == vofch_pkg::OFS_ADDR_B);
	wire wr_ac   = wr & (wb_adr_i == vofch_pkg::OFS_ADDR_C);
	wire wr_ad   = wr & (wb_adr_i == vofch_pkg::OFS_ADDR_D);
	wire wr_cs   = wr & (wb_adr_i == vofch_pkg::OFS_CHR_STRIDE);
	wire wr_ls   = wr & (wb_adr_i == vofch_pkg::OFS_LUM_STRIDE);
	wire wr_ctl  = wr & (wb_adr_i == vofch_pkg::OFS_CTRL);
	wire wr_msk  = wr & (wb_adr_i == vofch_pkg::OFS_MASK);
	wire rd_sts  = rd & (wb_adr_i == vofch_pkg::OFS_STATUS);

	// read mux; unmapped reads return zero
	logic [31:0] rdata;
	always_comb begin
		unique case (wb_adr_i)
			vofch_pkg::OFS_IMAGE_SIZE: rdata = img_sz_r;
			vofch_pkg::OFS_THR_POS:    rdata = thr_pos_r;
			vofch_pkg::OFS_OVL_START:  rdata = ovl_st_r;
			vofch_pkg::OFS_OVL_SIZE:   rdata = ovl_sz_r;
			vofch_pkg::OFS_ADDR_A:     rdata = addr_a_r;
			vofch_pkg::OFS_ADDR_B:     rdata = addr_b_r;
			vofch_pkg::OFS_ADDR_C:     rdata = addr_c_r;
			vofch_pkg::OFS_ADDR_D:     rdata = addr_d_r;
			vofch_pkg::OFS_CHR_STRIDE: rdata = chr_str_r;
			vofch_pkg::OFS_LUM_STRIDE: rdata = lum_str_r;
			vofch_pkg::OFS_CTRL:       rdata = {28'h0000000, ctrl_r};
			vofch_pkg::OFS_STATUS:     rdata = {30'h00000000, sts_r};
			vofch_pkg::OFS_MASK:       rdata = {30'h00000000, mask_r};
			default:                   rdata = vofch_pkg::RST_ZERO;
		endcase
	end

	// one-cycle ack, read data registered
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= vofch_pkg::RST_ZERO;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= rd ? rdata : wb_dat_o;
		end
	end

	// register writes with byte lanes
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			img_sz_r  <= vofch_pkg::RST_ZERO;
			thr_pos_r <= vofch_pkg::RST_ZERO;
			ovl_st_r  <= vofch_pkg::RST_ZERO;
			ovl_sz_r  <= vofch_pkg::RST_ZERO;
			addr_a_r  <= vofch_pkg::RST_ZERO;
			addr_b_r  <= vofch_pkg::RST_ZERO;
			addr_c_r  <= vofch_pkg::RST_ZERO;
			addr_d_r  <= vofch_pkg::RST_ZERO;
			chr_str_r <= vofch_pkg::RST_ZERO;
			lum_str_r <= vofch_pkg::RST_ZERO;
			ctrl_r    <= 4'h0;
			mask_r    <= 2'h0;
		end else begin
			if (wr_img) img_sz_r  <= lanes(img_sz_r, wb_dat_i, wb_sel_i);
			if (wr_thr) thr_pos_r <= lanes(thr_pos_r, wb_dat_i, wb_sel_i);
			if (wr_ost) ovl_st_r  <= lanes(ovl_st_r, wb_dat_i, wb_sel_i);
			if (wr_osz) ovl_sz_r  <= lanes(ovl_sz_r, wb_dat_i, wb_sel_i);
			if (wr_aa)  addr_a_r  <= lanes(addr_a_r, wb_dat_i, wb_sel_i);
			if (wr_ab)  addr_b_r  <= lanes(addr_b_r, wb_dat_i, wb_sel_i);
			if (wr_ac)  addr_c_r  <= lanes(addr_c_r, wb_dat_i, wb_sel_i);
			if (wr_ad)  addr_d_r  <= lanes(addr_d_r, wb_dat_i, wb_sel_i);
			if (wr_cs)  chr_str_r <= lanes(chr_str_r, wb_dat_i, wb_sel_i);
			if (wr_ls)  lum_str_r <= lanes(lum_str_r, wb_dat_i, wb_sel_i);
			if (wr_ctl && wb_sel_i[0]) ctrl_r <= wb_dat_i[3:0];
			if (wr_msk && wb_sel_i[0]) mask_r <= wb_dat_i[1:0];
		end
	end

	// mode decode
	wire [1:0] mode_w  = ctrl_r[vofch_pkg::C_MODE +: 2];
	wire refresh       = mode_w == vofch_pkg::VOFCH_REFRESH;
	wire stream        = mode_w == vofch_pkg::VOFCH_STREAM;
	wire alpha_fmt     = ctrl_r[vofch_pkg::C_AFMT];

	// pin synchroniser
	logic [2:0] pins_s;
	vofch_sync #(.W(3)) u_sync (
		.mclk (mclk),
		.rstn (rstn),
		.d    ({window_pin, line_pin, frame_pin}),
		.q    (pins_s)
	);

	// edge detect on synchronised pins
	logic [1:0] pins_d_r;
	always_ff @(posedge mclk) begin
		if (!rstn) pins_d_r <= 2'h0;
		else       pins_d_r <= pins_s[1:0];
	end
	wire frame_go = pins_s[0] & ~pins_d_r[0];
	wire line_go  = pins_s[1] & ~pins_d_r[1];
	wire win_on   = pins_s[2];

	// threshold shadow, a new value takes effect at the next frame edge
	logic [9:0]  thr_f_r;   // threshold for this frame
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			thr_f_r <= 10'h000;
		end else if (frame_go) begin
			thr_f_r <= fld(thr_pos_r, vofch_pkg::F_HI);  // [RL2]
		end
	end

	// window line and pixel counters
	logic [10:0] wline_r;
	logic [10:0] wpix_r;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wline_r <= 11'h000;
			wpix_r  <= 11'h000;
		end else if (frame_go) begin
			wline_r <= 11'h000;
			wpix_r  <= 11'h000;
		end else if (line_go) begin
			wline_r <= wline_r + 11'h001;
			wpix_r  <= 11'h000;
		end else if (win_on) begin
			wpix_r  <= wpix_r + 11'h001;
		end
	end

	// image placement; line counter is one ahead after a line edge
	wire [10:0] row_w   = wline_r - 11'h001;
	wire [10:0] voff    = {1'b0, fld(thr_pos_r, vofch_pkg::F_MID)};
	wire [10:0] hoff    = {1'b0, fld(thr_pos_r, vofch_pkg::F_LO)};
	wire [10:0] img_h   = img_sz_r[26:16];
	wire [10:0] img_w   = img_sz_r[10:0];
	wire [10:0] img_row = row_w - voff;
	wire [10:0] img_col = wpix_r - hoff;
	wire row_in = (wline_r != 11'h000) && inside_of(row_w, voff, img_h);  // [RL1] [RL3]
	wire col_in = win_on && inside_of(wpix_r, hoff, img_w);  // [RL1] [RL3]
	// next line starts an image line
	wire [10:0] nimg    = wline_r - voff;
	wire nrow_in = inside_of(wline_r, voff, img_h);

	// overlay placement inside the image
	wire [10:0] o_row   = {1'b0, fld(ovl_st_r, vofch_pkg::F_HI)};
	wire [10:0] o_col   = {1'b0, fld(ovl_st_r, vofch_pkg::F_MID)};
	wire [10:0] o_h     = {1'b0, fld(ovl_sz_r, vofch_pkg::F_HI)};
	wire [10:0] o_w     = {1'b0, fld(ovl_sz_r, vofch_pkg::F_MID)};
	wire orow_in = row_in && inside_of(img_row, o_row, o_h);  // [RL4]
	wire ocol_in = col_in && inside_of(img_col, {o_col[10:1], 1'b0}, o_w);  // [RL5]
	wire nrow_ov = nrow_in && inside_of(nimg, o_row, o_h);  // [RL4]

	// blend weight pick
	wire [7:0] w_one   = ovl_st_r[7:0];
	wire [7:0] w_zero  = ovl_sz_r[7:0];
	wire [7:0] w_pick  = (!alpha_fmt || ovl_alpha_bit) ? w_one : w_zero;  // [RL6]

	// image and overlay flags, blend weight
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			img_on_r <= 1'b0;
			ovl_on_r <= 1'b0;
			alpha_r  <= 8'h00;
		end else begin
			img_on_r <= row_in && col_in;
			ovl_on_r <= orow_in && ocol_in;
			alpha_r  <= (orow_in && ocol_in) ? w_pick : 8'h00;  // [RL6]
		end
	end

	// steppers: load at frame, step on every image line after the first; overlay steps on each overlay line after its first
	wire        step_img = line_go && nrow_in && (nimg != 11'h000);
	wire        step_ovl = line_go && nrow_ov && (nimg != o_row);
	wire [31:0] a_luma;
	wire [31:0] a_cb;
	wire [31:0] a_cr;
	wire [31:0] a_ovl;

	vofch_step u_luma (
		.mclk   (mclk),
		.rstn   (rstn),
		.load   (frame_go),
		.step   (step_img),
		.start  (addr_a_r),
		.stride (lum_str_r[15:0]),
		.addr   (a_luma)
	);
	vofch_step u_cb (
		.mclk   (mclk),
		.rstn   (rstn),
		.load   (frame_go),
		.step   (step_img),
		.start  (addr_b_r),
		.stride (chr_str_r[15:0]),
		.addr   (a_cb)
	);
	vofch_step u_cr (
		.mclk   (mclk),
		.rstn   (rstn),
		.load   (frame_go),
		.step   (step_img),
		.start  (addr_c_r),
		.stride (chr_str_r[31:16]),
		.addr   (a_cr)
	);
	// overlay start written between frames is taken at the next frame edge
	vofch_step u_ovl (
		.mclk   (mclk),
		.rstn   (rstn),
		.load   (frame_go),
		.step   (step_ovl),
		.start  (addr_d_r),  // [RL11]
		.stride (lum_str_r[31:16]),
		.addr   (a_ovl)
	);

	// fetch pulse waits a cycle so the stepped line address is on the outputs
	logic go_d_r;
	always_ff @(posedge mclk) go_d_r <= rstn && line_go && nrow_in;

	// fetch outputs by mode
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			fetch_go_r   <= 1'b0;
			fetch_luma_r <= vofch_pkg::RST_ZERO;
			fetch_cb_r   <= vofch_pkg::RST_ZERO;
			fetch_cr_r   <= vofch_pkg::RST_ZERO;
			fetch_ovl_r  <= vofch_pkg::RST_ZERO;
			len_one_r    <= 24'h000000;
			len_two_r    <= 24'h000000;
		end else if (refresh) begin
			fetch_go_r   <= go_d_r;  // [RL14]
			fetch_luma_r <= a_luma;  // [RL8]
			fetch_cb_r   <= a_cb;  // [RL9]
			fetch_cr_r   <= a_cr;  // [RL10]
			fetch_ovl_r  <= a_ovl;  // [RL11]
			len_one_r    <= 24'h000000;
			len_two_r    <= 24'h000000;
		end else begin
			fetch_go_r   <= frame_go;
			fetch_luma_r <= addr_a_r;  // [RL8]
			fetch_cb_r   <= stream ? addr_b_r : vofch_pkg::RST_ZERO;  // [RL9]
			fetch_cr_r   <= vofch_pkg::RST_ZERO;
			fetch_ovl_r  <= vofch_pkg::RST_ZERO;
			len_one_r    <= addr_c_r[23:0];  // [RL10]
			len_two_r    <= stream ? addr_d_r[23:0] : 24'h000000;  // [RL12]
		end
	end

	// events: threshold line and frame start
	wire thr_hit = line_go && nrow_in && (nimg == {1'b0, thr_f_r});  // [RL2]
	wire [1:0] ev = {frame_go, thr_hit};
	wire [1:0] mask_nxt = (wr_msk && wb_sel_i[0]) ? wb_dat_i[1:0] : mask_r;
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sts_r <= 2'h0;
			irq_r <= 1'b0;
		end else begin
			sts_r <= (rd_sts ? 2'h0 : sts_r) | ev;  // set beats read-clear
			irq_r <= |(((rd_sts ? 2'h0 : sts_r) | ev) & mask_nxt);  // follows next status
		end
	end

	ack_pulse_a: assert property (@(posedge mclk) disable iff (!rstn)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	thr_irq_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL2]
		thr_hit |=> sts_r[vofch_pkg::S_THR])
		else $error("threshold line did not set status");
	irq_level_a: assert property (@(posedge mclk) disable iff (!rstn)
		(|(sts_r & mask_r)) |-> irq_r)
		else $error("interrupt low with unmasked status");
	alpha_one_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL6]
		orow_in && ocol_in && alpha_fmt && ovl_alpha_bit |=> alpha_r == $past(w_one))
		else $error("wrong weight for alpha bit one");
	alpha_zero_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL6]
		orow_in && ocol_in && alpha_fmt && !ovl_alpha_bit |=> alpha_r == $past(w_zero))
		else $error("wrong weight for alpha bit zero");
	ovl_in_img_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL4]
		ovl_on_r |-> img_on_r)
		else $error("overlay shown outside the image");
	img_first_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL3]
		row_in && win_on && wpix_r == hoff && img_w != 11'h000 |=> img_on_r)
		else $error("image not at horizontal offset");
	len_mode_a: assert property (@(posedge mclk) disable iff (!rstn) // [RL12]
		stream |=> len_two_r == $past(addr_d_r[23:0]))
		else $error("second length not from overlay address");
endmodule
`default_nettype wire

// [test/vofch_sink_model.sv]
// far-side video sink model: supplies frame, line and window timing and the alpha bit
`default_nettype none
module vofch_sink_model (
	// clock
	input  wire logic mclk,
	// timing pins towards the block
	output logic      frame_pin,
	output logic      line_pin,
	output logic      window_pin,
	// alpha bit of the fetched overlay pixel
	output logic      ovl_alpha_bit
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle levels at time zero
	initial begin
		frame_pin     = 1'b0;
		line_pin      = 1'b0;
		window_pin    = 1'b0;
		ovl_alpha_bit = 1'b0;
	end

	// one frame: frame edge, then lines each with 16 window pixels; call after a rising edge
	task automatic send_frame(input int nlines, input logic abit);
		ovl_alpha_bit <= abit;
		frame_pin     <= 1'b1;
		repeat (2) @(posedge mclk);
		frame_pin <= 1'b0;
		repeat (6) @(posedge mclk);
		for (int i = 0; i < nlines; i++) begin
			line_pin <= 1'b1;
			repeat (2) @(posedge mclk);
			line_pin <= 1'b0;
			repeat (6) @(posedge mclk);
			window_pin <= 1'b1;
			repeat (16) @(posedge mclk);
			window_pin <= 1'b0;
			repeat (6) @(posedge mclk);
		end
		repeat (8) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// [test/tb_video_out_image_overlay_fetch.sv]
// self-checking bench for the image placement, overlay and fetch address unit
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_video_out_image_overlay_fetch;
	timeunit 1ns;
	timeprecision 1ps;

	// clock, reset and bus
	logic        mclk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	// pins and outputs
	logic        frame_pin, line_pin, window_pin, ovl_alpha_bit;
	logic        img_on_r, ovl_on_r, fetch_go_r, irq_r;
	logic [7:0]  alpha_r, exp_alpha;
	logic [31:0] fetch_luma_r, fetch_cb_r, fetch_cr_r, fetch_ovl_r;
	logic [23:0] len_one_r, len_two_r;
	// bookkeeping
	int          miscompares, n_checks, img_cyc, ovl_cyc, alpha_bad, go_cnt, wcnt;
	int          first_img, first_ovl, fimg_a;
	logic        win_q, img_q, ovl_q;
	logic [31:0] cap [4][4];
	logic [23:0] cap_len [2];
	// image 3x8, overlay at row 1 column 2 size 2x4, planes and strides
	localparam logic [31:0] CFG [10] = '{32'h0003_0008, 32'h0020_0400, 32'h0010_08a5,
		32'h0020_103c, 32'h1000_0000, 32'h2000_0000, 32'h3000_0000, 32'h4000_0000,
		32'h0050_00a0, 32'h0020_0140};
	localparam logic [15:0] STR [4] = '{16'h0140, 16'h00a0, 16'h0050, 16'h0020};
	// overlay line shown at image lines 0..2: start until its second row
	localparam int          OLN [3] = '{0, 0, 1};

	vofch_top DUT (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_pin(frame_pin), .line_pin(line_pin),
		.window_pin(window_pin), .ovl_alpha_bit(ovl_alpha_bit), .img_on_r(img_on_r),
		.ovl_on_r(ovl_on_r), .alpha_r(alpha_r), .fetch_go_r(fetch_go_r),
		.fetch_luma_r(fetch_luma_r), .fetch_cb_r(fetch_cb_r), .fetch_cr_r(fetch_cr_r),
		.fetch_ovl_r(fetch_ovl_r), .len_one_r(len_one_r), .len_two_r(len_two_r), .irq_r(irq_r));

	vofch_sink_model SINK (.mclk(mclk), .frame_pin(frame_pin), .line_pin(line_pin),
		.window_pin(window_pin), .ovl_alpha_bit(ovl_alpha_bit));

	// free-running clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// monitor: pixel counts, first positions from window start, fetch captures
	always @(posedge mclk) begin
		if (window_pin && !win_q) wcnt = 0;
		else wcnt = wcnt + 1;
		win_q = window_pin;
		if (img_on_r === 1'b1) img_cyc++;
		if (ovl_on_r === 1'b1) begin
			ovl_cyc++;
			if (alpha_r !== exp_alpha) alpha_bad++;
		end
		if (img_on_r === 1'b1 && img_q !== 1'b1 && first_img < 0) first_img = wcnt;
		if (ovl_on_r === 1'b1 && ovl_q !== 1'b1 && first_ovl < 0) first_ovl = wcnt;
		img_q = img_on_r;
		ovl_q = ovl_on_r;
		if (fetch_go_r === 1'b1 && go_cnt < 4) begin
			cap[go_cnt] = '{fetch_luma_r, fetch_cb_r, fetch_cr_r, fetch_ovl_r};
			cap_len = '{len_one_r, len_two_r};
			go_cnt++;
		end
	end

	// closing report
	task automatic test_done();
		if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		if (k >= 50) begin
			miscompares++;
			test_done();
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge mclk);
	endtask

	// clear the monitor away from the sampling edge, then run one frame of five lines
	task automatic run_frame(input logic abit, input logic [7:0] ea);
		@(negedge mclk);
		{img_cyc, ovl_cyc, alpha_bad, go_cnt, first_img, first_ovl} = {0, 0, 0, 0, -1, -1};
		exp_alpha = ea;
		@(posedge mclk);
		SINK.send_frame(5, abit);
	endtask

	// reset values, unmapped place, readback of the register table
	task automatic t_regs();
		for (int i = 0; i <= 16'h40; i += 4) begin
			wb_io(1'b0, 8'(i), 32'h0);
			`CHK(q, vofch_pkg::RST_ZERO)
		end
		wb_io(1'b1, 8'h40, 32'hdead_beef);
		wb_io(1'b0, 8'h40, 32'h0);
		`CHK(q, 32'h0000_0000)
		for (int i = 0; i < 10; i++) wb_io(1'b1, 8'(4 * i), CFG[i]);
		for (int i = 0; i < 10; i++) begin
			wb_io(1'b0, 8'(4 * i), 32'h0);
			`CHK(q, CFG[i])
		end
	endtask

	// refresh mode: placement, overlay, alpha one, line addresses, threshold interrupt
	task automatic t_frame_a();
		wb_io(1'b1, vofch_pkg::OFS_CTRL, 32'h0000_0008);
		wb_io(1'b1, vofch_pkg::OFS_MASK, 32'h0000_0001);
		run_frame(1'b1, 8'ha5);
		fimg_a = first_img;
		`CHK(img_cyc, 24)
		`CHK(ovl_cyc, 8)
		`CHK(first_ovl - first_img, 2)
		`CHK(alpha_bad, 0)
		`CHK(go_cnt, 3)
		for (int n = 0; n < 3; n++)
			for (int p = 0; p < 4; p++)
				`CHK(cap[n][p], CFG[4 + p] + 32'(p == 3 ? OLN[n] : n) * {16'h0, STR[p]})
		`CHK(irq_r, 1'b1)
		wb_io(1'b0, vofch_pkg::OFS_STATUS, 32'h0);
		`CHK(q[vofch_pkg::S_THR], 1'b1)
		@(posedge mclk);
		`CHK(irq_r, 1'b0)
	endtask

	// new threshold past the image and shifted image: alpha zero, no interrupt
	task automatic t_frame_b();
		wb_io(1'b1, vofch_pkg::OFS_THR_POS, 32'h0050_0402);
		run_frame(1'b0, 8'h3c);
		`CHK(first_img - fimg_a, 2)
		`CHK(ovl_cyc, 8)
		`CHK(alpha_bad, 0)
		`CHK(irq_r, 1'b0)
		wb_io(1'b0, vofch_pkg::OFS_STATUS, 32'h0);
		`CHK(q[vofch_pkg::S_THR], 1'b0)
		`CHK(q[vofch_pkg::S_FRAME], 1'b1)
	endtask

	// streaming then message mode: buffer starts, 24-bit lengths, one fetch per frame
	task automatic t_stream();
		wb_io(1'b1, vofch_pkg::OFS_ADDR_C, 32'hff00_0400);
		wb_io(1'b1, vofch_pkg::OFS_ADDR_D, 32'h0000_0800);
		wb_io(1'b1, vofch_pkg::OFS_CTRL, 32'h0000_0009);
		run_frame(1'b0, 8'h3c);
		`CHK(go_cnt, 1)
		`CHK(cap[0][0], CFG[4])
		`CHK(cap[0][1], CFG[5])
		`CHK(cap_len[0], 24'h00_0400)
		`CHK(cap_len[1], 24'h00_0800)
		`CHK(cap[0][2], 32'h0000_0000)
		// message mode without alpha format: weight one on every overlay pixel
		wb_io(1'b1, vofch_pkg::OFS_CTRL, 32'h0000_0002);
		run_frame(1'b0, 8'ha5);
		`CHK(go_cnt, 1)
		`CHK(alpha_bad, 0)
		`CHK(cap[0][0], CFG[4])
		`CHK(cap[0][1], 32'h0000_0000)
		`CHK(cap_len[0], 24'h00_0400)
		`CHK(cap_len[1], 24'h00_0000)
	endtask

	// main sequence
	initial begin
		{miscompares, n_checks, wcnt} = {0, 0, 0};
		{win_q, img_q, ovl_q} = 3'b000;
		exp_alpha = 8'h00;
		rstn      = 1'b0;
		wb_cyc_i  = 1'b0;
		wb_stb_i  = 1'b0;
		wb_we_i   = 1'b0;
		wb_adr_i  = 8'h00;
		wb_sel_i  = 4'hf;
		wb_dat_i  = 32'h0;
		repeat (8) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_frame_a();
		t_frame_b();
		t_stream();
		test_done();
	end
endmodule
`undef CHK
`default_nettype wire
